// ==== core/spc_pkg.sv ====
// Constants for the synchroniser pin control block.
// Assumes a 50 MHz system clock and a plain one-cycle register port.
package spc_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_KHZ       = 50000;
    localparam int RST_MIN_NS    = 300;
    localparam int RST_MIN_CYC   = (RST_MIN_NS * CLK_KHZ + 999999) / 1000000;
    localparam int FA_MIN_PW_NS  = 5;
    localparam int FA_MIN_PW_RAW = (FA_MIN_PW_NS * CLK_KHZ + 999999) / 1000000;
    localparam int FA_MIN_PW_CYC = (FA_MIN_PW_RAW < 1) ? 1 : FA_MIN_PW_RAW;
    localparam int ACT_WIN_US    = 1000;
    localparam int ACT_WIN_CYC   = ACT_WIN_US * (CLK_KHZ / 1000);
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_REFSEL = 8'h04;
    localparam logic [7:0] OFS_TCLK   = 8'h08;
    localparam logic [7:0] OFS_PCLK   = 8'h0c;
    localparam logic [7:0] OFS_DCLK   = 8'h10;
    localparam logic [7:0] OFS_FPCFG  = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_FREERUN = 0;
    localparam int CTRL_MODESRC = 1;
    localparam int CTRL_DIFFEN  = 2;
    localparam int CTRL_DIFFSRC = 3;
    localparam int REFSEL_AUTO  = 2;
    // ------------------------------------------------------------
    // Codes and reset values
    // ------------------------------------------------------------
    localparam logic [3:0]  CTRL_RST    = 4'h4;
    localparam logic [2:0]  REFSEL_RST  = 3'h4;
    localparam logic [2:0]  TCLK_77M76  = 3'h5;
    localparam logic [2:0]  TCLK_MAX    = 3'h5;
    localparam logic [13:0] PCLK_2M048  = 14'h0100;
    localparam logic [13:0] PCLK_MAX    = 14'h25f8;
    localparam logic [1:0]  DCLK_622M08 = 2'h2;
    localparam logic [1:0]  DCLK_MAX    = 2'h2;
    localparam logic [3:0]  FP_8K       = 4'h0;
    localparam logic [3:0]  FP_FREQ_MAX = 4'h3;
    localparam logic [15:0] FPCFG_RST   = 16'h0000;
    localparam logic [1:0]  REF_MAX     = 2'h2;
endpackage

// ==== core/spc_sync.sv ====
// Three-stage pin synchroniser with agreement filter.
// Assumes asynchronous pins; output changes when stages two and three agree.
module spc_sync #(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         ce_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    wire  [W-1:0] q_next = (s2_reg & s3_reg) | (q_o & (s2_reg | s3_reg));

    if (W < 1) begin : g_bad_width
        $error("spc_sync width must be positive");
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s1_reg <= RST_VAL;
            s2_reg <= RST_VAL;
            s3_reg <= RST_VAL;
            q_o    <= RST_VAL;
        end else if (ce_i) begin
            s1_reg <= d_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            q_o    <= q_next;
        end
    end
endmodule

// ==== core/spc_edge.sv ====
// Rising edge detector with per-input activity window.
// Assumes inputs already synchronised to the system clock.
module spc_edge #(
    parameter int W   = 3,
    parameter int WIN = 50000
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         ce_i,
    input  wire logic [W-1:0] lvl_i,
    output logic      [W-1:0] rise_o,
    output logic      [W-1:0] active_o
);
    localparam int CW = $clog2(WIN + 1);
    localparam logic [CW-1:0] WIN_C = CW'(WIN);

    logic [W-1:0] prev_reg;
    wire  [W-1:0] rise_next = lvl_i & ~prev_reg;

    if (W < 1 || WIN < 1) begin : g_bad_param
        $error("spc_edge needs positive width and window");
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            prev_reg <= '0;
            rise_o   <= '0;
        end else if (ce_i) begin
            prev_reg <= lvl_i;
            rise_o   <= rise_next;
        end
    end

    // Activity timers reload on each edge
    for (genvar i = 0; i < W; i++) begin : g_act
        logic [CW-1:0] cnt_reg;
        always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                cnt_reg     <= '0;
                active_o[i] <= 1'b0;
            end else if (ce_i) begin
                cnt_reg     <= rise_next[i] ? WIN_C : (cnt_reg != '0 ? cnt_reg - 1'b1 : cnt_reg);
                active_o[i] <= rise_next[i] || (cnt_reg > 1);
            end
        end
    end
endmodule

// ==== core/spc_top.sv ====
// Pin control and default configuration of the line-card synchroniser.
// Assumes pins are asynchronous; register port is on the system clock.
module spc_top #(
    parameter int ACT_WIN = spc_pkg::ACT_WIN_CYC
) (
    input  wire logic        CLK_SYS_I,
    input  wire logic        RST_I,
    input  wire logic        CE_I,
    input  wire logic        RESET_N_I,
    input  wire logic        MODE_SEL_I,
    input  wire logic        DIFF_EN_I,
    input  wire logic        REFERENCE_INPUT_A_I,
    input  wire logic        REFERENCE_INPUT_B_I,
    input  wire logic        REFERENCE_INPUT_C_I,
    input  wire logic        FRAME_ALIGN_IN_A_I,
    input  wire logic        FRAME_ALIGN_IN_B_I,
    input  wire logic        FRAME_ALIGN_IN_C_I,
    input  wire logic [7:0]  ADDR_I,
    input  wire logic [31:0] WDATA_I,
    input  wire logic        WR_I,
    input  wire logic        RD_I,
    output logic      [31:0] RDATA_O,
    output logic             MODE_FREERUN_O,
    output logic             DIFF_DRV_EN_O,
    output logic      [1:0]  REF_SEL_O,
    output logic             FRAME_ALIGN_O,
    output logic      [2:0]  TCLK_CODE_O,
    output logic      [13:0] PCLK_MULT_O,
    output logic      [1:0]  DCLK_CODE_O,
    output logic      [7:0]  TELECOM_FRAME_PULSE_OUT_CFG_O,
    output logic      [7:0]  PROG_FRAME_PULSE_OUT_CFG_O
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] ctl_s;
    logic [5:0] sig_s;
    logic [2:0] ref_act;
    logic [2:0] fa_rise;

    spc_sync #(.W(3), .RST_VAL(3'h6)) u_ctl_sync (
        .clk_i (CLK_SYS_I),
        .rst_i (RST_I),
        .ce_i  (CE_I),
        .d_i   ({MODE_SEL_I, DIFF_EN_I, RESET_N_I}),
        .q_o   (ctl_s)
    );

    spc_sync #(.W(6), .RST_VAL(6'h00)) u_sig_sync (
        .clk_i (CLK_SYS_I),
        .rst_i (RST_I),
        .ce_i  (CE_I),
        .d_i   ({FRAME_ALIGN_IN_C_I, FRAME_ALIGN_IN_B_I, FRAME_ALIGN_IN_A_I,
                 REFERENCE_INPUT_C_I, REFERENCE_INPUT_B_I, REFERENCE_INPUT_A_I}),
        .q_o   (sig_s)
    );

    spc_edge #(.W(3), .WIN(ACT_WIN)) u_ref_edge (
        .clk_i    (CLK_SYS_I),
        .rst_i    (RST_I),
        .ce_i     (CE_I),
        .lvl_i    (sig_s[2:0]),
        .rise_o   (),
        .active_o (ref_act)
    );

    // Edge of each align input, at least one cycle wide once filtered
    spc_edge #(.W(3), .WIN(spc_pkg::FA_MIN_PW_CYC)) u_fa_edge (
        .clk_i    (CLK_SYS_I),
        .rst_i    (RST_I),
        .ce_i     (CE_I),
        .lvl_i    (sig_s[5:3]),
        .rise_o   (fa_rise),
        .active_o ()
    );

    if (ACT_WIN < 2) begin : g_bad_win
        $error("spc_top activity window too short");
    end

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire in_reset = ~ctl_s[0];
    wire diff_pin = ctl_s[1];
    wire mode_pin = ctl_s[2];
    wire wr_ok    = WR_I && !in_reset;
    wire wr_ctrl  = wr_ok && ADDR_I == spc_pkg::OFS_CTRL;
    wire wr_ref   = wr_ok && ADDR_I == spc_pkg::OFS_REFSEL;
    wire wr_tclk  = wr_ok && ADDR_I == spc_pkg::OFS_TCLK;
    wire wr_pclk  = wr_ok && ADDR_I == spc_pkg::OFS_PCLK;
    wire wr_dclk  = wr_ok && ADDR_I == spc_pkg::OFS_DCLK;
    wire wr_fp    = wr_ok && ADDR_I == spc_pkg::OFS_FPCFG;

    function automatic logic fp_ok(input logic [7:0] c);
        fp_ok = c[3:0] <= spc_pkg::FP_FREQ_MAX;
    endfunction

    function automatic logic [1:0] first_act(input logic [2:0] a, input logic [1:0] d);
        first_act = a[0] ? 2'h0 : a[1] ? 2'h1 : a[2] ? 2'h2 : d;
    endfunction

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [3:0]  ctrl_reg;
    logic [2:0]  refsel_reg;
    logic        strap_reg;

    wire [3:0] ctrl_next =
        in_reset ? {spc_pkg::CTRL_RST[3:1], ~mode_pin} :
        wr_ctrl  ? WDATA_I[3:0] : ctrl_reg;
    wire [2:0] refsel_next =
        in_reset ? spc_pkg::REFSEL_RST :
        (wr_ref && WDATA_I[1:0] <= spc_pkg::REF_MAX) ? WDATA_I[2:0] : refsel_reg;
    wire [2:0] tclk_next =
        in_reset ? spc_pkg::TCLK_77M76 :
        (wr_tclk && WDATA_I[2:0] <= spc_pkg::TCLK_MAX) ? WDATA_I[2:0] : TCLK_CODE_O;
    wire [13:0] pclk_next =
        in_reset ? spc_pkg::PCLK_2M048 :
        (wr_pclk && WDATA_I[13:0] <= spc_pkg::PCLK_MAX) ? WDATA_I[13:0] : PCLK_MULT_O;
    wire [1:0] dclk_next =
        in_reset ? spc_pkg::DCLK_622M08 :
        (wr_dclk && WDATA_I[1:0] <= spc_pkg::DCLK_MAX) ? WDATA_I[1:0] : DCLK_CODE_O;
    wire [15:0] fp_cur = {PROG_FRAME_PULSE_OUT_CFG_O, TELECOM_FRAME_PULSE_OUT_CFG_O};
    wire [15:0] fp_next =
        in_reset ? spc_pkg::FPCFG_RST :
        (wr_fp && fp_ok(WDATA_I[7:0]) && fp_ok(WDATA_I[15:8])) ? WDATA_I[15:0] : fp_cur;

    // Operating mode and driver enable, pin high means normal mode
    wire mode_next =
        ctrl_next[spc_pkg::CTRL_MODESRC] ? ctrl_next[spc_pkg::CTRL_FREERUN] :
        ~mode_pin;
    wire diff_next =
        ctrl_next[spc_pkg::CTRL_DIFFSRC] ? ctrl_next[spc_pkg::CTRL_DIFFEN] :
        diff_pin;
    wire [1:0] sel_next =
        refsel_next[spc_pkg::REFSEL_AUTO] ? first_act(ref_act, REF_SEL_O) :
        refsel_next[1:0];
    wire fa_next  = fa_rise[REF_SEL_O];

    // ------------------------------------------------------------
    // Read back
    // ------------------------------------------------------------
    wire [31:0] status = {24'h0, strap_reg, fa_rise, ref_act, in_reset};
    wire [31:0] rd_next =
        !RD_I                          ? 32'h0 :
        ADDR_I == spc_pkg::OFS_CTRL    ? {28'h0, ctrl_reg} :
        ADDR_I == spc_pkg::OFS_REFSEL  ? {29'h0, refsel_reg} :
        ADDR_I == spc_pkg::OFS_TCLK    ? {29'h0, TCLK_CODE_O} :
        ADDR_I == spc_pkg::OFS_PCLK    ? {18'h0, PCLK_MULT_O} :
        ADDR_I == spc_pkg::OFS_DCLK    ? {30'h0, DCLK_CODE_O} :
        ADDR_I == spc_pkg::OFS_FPCFG   ? {16'h0, fp_cur} :
        ADDR_I == spc_pkg::OFS_STATUS  ? status : 32'h0;

    // ------------------------------------------------------------
    // State and outputs
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            ctrl_reg   <= spc_pkg::CTRL_RST;
            refsel_reg <= spc_pkg::REFSEL_RST;
            strap_reg  <= 1'b0;
        end else if (CE_I) begin
            ctrl_reg   <= ctrl_next;
            refsel_reg <= refsel_next;
            strap_reg  <= in_reset ? ~mode_pin : strap_reg;
        end
    end

    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            TCLK_CODE_O <= spc_pkg::TCLK_77M76;
            PCLK_MULT_O <= spc_pkg::PCLK_2M048;
            DCLK_CODE_O <= spc_pkg::DCLK_622M08;
            {PROG_FRAME_PULSE_OUT_CFG_O, TELECOM_FRAME_PULSE_OUT_CFG_O} <= spc_pkg::FPCFG_RST;
        end else if (CE_I) begin
            TCLK_CODE_O <= tclk_next;
            PCLK_MULT_O <= pclk_next;
            DCLK_CODE_O <= dclk_next;
            {PROG_FRAME_PULSE_OUT_CFG_O, TELECOM_FRAME_PULSE_OUT_CFG_O} <= fp_next;
        end
    end

    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            MODE_FREERUN_O <= 1'b0;
            DIFF_DRV_EN_O  <= 1'b1;
            REF_SEL_O      <= 2'h0;
            FRAME_ALIGN_O  <= 1'b0;
            RDATA_O        <= 32'h0;
        end else if (CE_I) begin
            MODE_FREERUN_O <= mode_next;
            DIFF_DRV_EN_O  <= diff_next;
            REF_SEL_O      <= sel_next;
            FRAME_ALIGN_O  <= fa_next;
            RDATA_O        <= rd_next;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (RST_I);

    sequence s_held_reset;
        CE_I && in_reset;
    endsequence

    sequence s_pin_mode;
        CE_I && !in_reset && !ctrl_reg[spc_pkg::CTRL_MODESRC] && !wr_ctrl;
    endsequence

    sequence s_auto_sel;
        CE_I && !in_reset && refsel_reg[spc_pkg::REFSEL_AUTO] && !wr_ref;
    endsequence

    a_reset_reload: assert property (s_held_reset |=>
        TCLK_CODE_O == spc_pkg::TCLK_77M76 && PCLK_MULT_O == spc_pkg::PCLK_2M048
        && ctrl_reg == {3'h2, ctrl_reg[0]})
        else $error("reset did not reload defaults");
    a_strap_sample: assert property (s_held_reset |=> strap_reg == !$past(mode_pin))
        else $error("mode strap not sampled during reset");
    a_mode_pin_follow: assert property (s_pin_mode |=> MODE_FREERUN_O == !$past(mode_pin))
        else $error("mode output not following pin");
    a_mode_reg_write: assert property (CE_I && wr_ctrl && WDATA_I[1] |=>
        MODE_FREERUN_O == $past(WDATA_I[0]))
        else $error("mode register write not applied");
    a_diff_pin_follow: assert property (CE_I && !ctrl_next[spc_pkg::CTRL_DIFFSRC] |=>
        DIFF_DRV_EN_O == $past(diff_pin))
        else $error("driver enable not following pin");
    a_tclk_range: assert property (TCLK_CODE_O <= spc_pkg::TCLK_MAX)
        else $error("telecom clock code out of range");
    a_fp_default: assert property (s_held_reset ##1 s_held_reset |->
        TELECOM_FRAME_PULSE_OUT_CFG_O[3:0] == spc_pkg::FP_8K
        && PROG_FRAME_PULSE_OUT_CFG_O[3:0] == spc_pkg::FP_8K)
        else $error("frame pulse default not 8 kHz");
    a_pclk_range: assert property (PCLK_MULT_O <= spc_pkg::PCLK_MAX)
        else $error("programmable clock multiple out of range");
    a_dclk_default: assert property (s_held_reset |=> DCLK_CODE_O == spc_pkg::DCLK_622M08)
        else $error("differential clock default lost");
    a_align_pair: assert property (CE_I && fa_rise[REF_SEL_O] |=> FRAME_ALIGN_O)
        else $error("align edge of selected reference lost");
    a_ref_manual: assert property (CE_I && !in_reset
        && !refsel_reg[spc_pkg::REFSEL_AUTO] && !wr_ref |=>
        REF_SEL_O == $past(refsel_reg[1:0]))
        else $error("manual reference choice not applied");
    a_rst_writes_off: assert property (s_held_reset ##1 (s_held_reset and WR_I) |=>
        $stable(PCLK_MULT_O))
        else $error("write accepted during reset");

    // ------------------------------------------------------------
    // Register port, pin control and selection assertions
    // ------------------------------------------------------------
    a_rd_idle: assert property (CE_I && !RD_I |=> RDATA_O == 32'h0)
        else $error("read data not zero without a read");
    a_rd_ctrl: assert property (CE_I && RD_I && ADDR_I == spc_pkg::OFS_CTRL |=>
        RDATA_O == {28'h0, $past(ctrl_reg)})
        else $error("control read back wrong");
    a_rd_tclk: assert property (CE_I && RD_I && ADDR_I == spc_pkg::OFS_TCLK |=>
        RDATA_O == {29'h0, $past(TCLK_CODE_O)})
        else $error("telecom clock read back wrong");
    a_rd_pclk: assert property (CE_I && RD_I && ADDR_I == spc_pkg::OFS_PCLK |=>
        RDATA_O == {18'h0, $past(PCLK_MULT_O)})
        else $error("programmable clock read back wrong");
    a_rd_dclk: assert property (CE_I && RD_I && ADDR_I == spc_pkg::OFS_DCLK |=>
        RDATA_O == {30'h0, $past(DCLK_CODE_O)})
        else $error("differential clock read back wrong");
    a_rd_fp: assert property (CE_I && RD_I && ADDR_I == spc_pkg::OFS_FPCFG |=>
        RDATA_O == {16'h0, $past(PROG_FRAME_PULSE_OUT_CFG_O),
        $past(TELECOM_FRAME_PULSE_OUT_CFG_O)})
        else $error("frame pulse read back wrong");

    a_tclk_write: assert property (CE_I && wr_tclk
        && WDATA_I[2:0] <= spc_pkg::TCLK_MAX |=> TCLK_CODE_O == $past(WDATA_I[2:0]))
        else $error("telecom clock write not applied");
    a_tclk_refuse: assert property (CE_I && wr_tclk
        && WDATA_I[2:0] > spc_pkg::TCLK_MAX |=> $stable(TCLK_CODE_O))
        else $error("out of range telecom clock code accepted");
    a_pclk_write: assert property (CE_I && wr_pclk
        && WDATA_I[13:0] <= spc_pkg::PCLK_MAX |=> PCLK_MULT_O == $past(WDATA_I[13:0]))
        else $error("programmable clock write not applied");
    a_fp_range: assert property (
        TELECOM_FRAME_PULSE_OUT_CFG_O[3:0] <= spc_pkg::FP_FREQ_MAX
        && PROG_FRAME_PULSE_OUT_CFG_O[3:0] <= spc_pkg::FP_FREQ_MAX)
        else $error("frame pulse frequency code out of range");
    a_dclk_range: assert property (DCLK_CODE_O <= spc_pkg::DCLK_MAX)
        else $error("differential clock code out of range");

    a_mode_reset_pin: assert property (s_held_reset |=>
        MODE_FREERUN_O == !$past(mode_pin))
        else $error("mode output not following pin in reset");
    a_diff_reset_pin: assert property (s_held_reset |=>
        DIFF_DRV_EN_O == $past(diff_pin))
        else $error("driver enable not following pin in reset");
    a_diff_reg_write: assert property (CE_I && wr_ctrl && WDATA_I[3] |=>
        DIFF_DRV_EN_O == $past(WDATA_I[2]))
        else $error("driver enable register write not applied");
    a_strap_hold: assert property (CE_I && !in_reset |=> $stable(strap_reg))
        else $error("mode strap changed outside reset");

    a_ref_range: assert property (REF_SEL_O <= spc_pkg::REF_MAX)
        else $error("selected reference out of range");
    a_ref_auto_low: assert property (s_auto_sel ##0 (ref_act[1:0] == 2'h2) |=>
        REF_SEL_O == 2'h1)
        else $error("automatic choice missed the lowest active reference");
    a_align_other: assert property (CE_I && !fa_rise[REF_SEL_O] |=> !FRAME_ALIGN_O)
        else $error("align pulse without edge on the selected input");
endmodule

// ==== sim/spc_board.sv ====
// Board model: reset pin, mode and enable straps, references and align inputs.
// Assumes one system clock; bench requests are one-cycle pulses after an edge.
module spc_board (
    input  wire logic       clk_i,
    input  wire logic       rst_req_i,
    input  wire logic       mode_i,
    input  wire logic       diff_i,
    input  wire logic [2:0] ref_on_i,
    input  wire logic [2:0] align_req_i,
    output logic            reset_n_o,
    output logic            mode_sel_o,
    output logic            diff_en_o,
    output logic      [2:0] ref_o,
    output logic      [2:0] align_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Reset from power-up, then longer than the minimum width on request
    int unsigned rst_cnt = spc_pkg::RST_MIN_CYC + 5;
    logic [2:0]  align_q = 3'h0;
    logic [1:0]  div     = 2'h0;

    assign reset_n_o  = (rst_cnt == 0);
    assign mode_sel_o = mode_i;
    assign diff_en_o  = diff_i;
    // Idle references sit at the pulled-down level
    assign ref_o      = ref_on_i & {3{div[1]}};
    // Align pulses are two clocks wide, above the minimum width
    assign align_o    = align_req_i | align_q;

    always @(posedge clk_i) begin
        div     <= div + 2'h1;
        align_q <= align_req_i;
        if (rst_req_i)
            rst_cnt <= spc_pkg::RST_MIN_CYC + 1;
        else if (rst_cnt != 0)
            rst_cnt <= rst_cnt - 1;
    end
endmodule

// ==== sim/tb_top.sv ====
// Self-checking bench for the synchroniser pin control block.
// Assumes the board model drives the pins and the bench drives the register port.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int WIN = 16;
    logic        clk, rst, ce, wr, rd, rst_req, mode_lvl, diff_lvl;
    logic        reset_n, mode_sel, diff_en, mode_fr, diff_drv, falign;
    logic [2:0]  ref_on, align_req, refs, aligns, tclk;
    logic [7:0]  addr, tfp, pfp;
    logic [31:0] wdata, rdata;
    logic [1:0]  ref_sel, dclk;
    logic [13:0] pclk;
    int          fail_count = 0;
    int          cmp_count  = 0;
    logic [7:0]  ofs[4]  = '{spc_pkg::OFS_TCLK, spc_pkg::OFS_PCLK,
                             spc_pkg::OFS_DCLK, spc_pkg::OFS_FPCFG};
    logic [31:0] dflt[4] = '{{29'h0, spc_pkg::TCLK_77M76}, {18'h0, spc_pkg::PCLK_2M048},
                             {30'h0, spc_pkg::DCLK_622M08}, 32'h0};
    logic [31:0] good[4] = '{32'h3, 32'h25f8, 32'h1, 32'h1230};
    logic [31:0] bad[4]  = '{32'h6, 32'h25f9, 32'h3, 32'h0004};

    spc_top #(.ACT_WIN(WIN)) spc_top_i (
        .CLK_SYS_I(clk), .RST_I(rst), .CE_I(ce), .RESET_N_I(reset_n),
        .MODE_SEL_I(mode_sel), .DIFF_EN_I(diff_en),
        .REFERENCE_INPUT_A_I(refs[0]), .REFERENCE_INPUT_B_I(refs[1]),
        .REFERENCE_INPUT_C_I(refs[2]), .FRAME_ALIGN_IN_A_I(aligns[0]),
        .FRAME_ALIGN_IN_B_I(aligns[1]), .FRAME_ALIGN_IN_C_I(aligns[2]),
        .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
        .MODE_FREERUN_O(mode_fr), .DIFF_DRV_EN_O(diff_drv), .REF_SEL_O(ref_sel),
        .FRAME_ALIGN_O(falign), .TCLK_CODE_O(tclk), .PCLK_MULT_O(pclk),
        .DCLK_CODE_O(dclk), .TELECOM_FRAME_PULSE_OUT_CFG_O(tfp),
        .PROG_FRAME_PULSE_OUT_CFG_O(pfp));

    spc_board spc_board_i (
        .clk_i(clk), .rst_req_i(rst_req), .mode_i(mode_lvl), .diff_i(diff_lvl),
        .ref_on_i(ref_on), .align_req_i(align_req), .reset_n_o(reset_n),
        .mode_sel_o(mode_sel), .diff_en_o(diff_en), .ref_o(refs), .align_o(aligns));

    // ----------------------------------------------------------------
    // Clock and common tasks
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic summarize();
        if (fail_count == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask

    task automatic align(input logic [2:0] m, input logic [31:0] exp);
        logic [31:0] n;
        n = 0;
        @(posedge clk);
        align_req <= m;
        @(posedge clk);
        align_req <= 3'h0;
        repeat (12) begin
            @(posedge clk);
            #1;
            if (falign === 1'b1)
                n++;
        end
        chk(n, exp);
    endtask

    function automatic logic [31:0] cfg_out(input logic [7:0] a);
        case (a)
            spc_pkg::OFS_TCLK: return {29'h0, tclk};
            spc_pkg::OFS_PCLK: return {18'h0, pclk};
            spc_pkg::OFS_DCLK: return {30'h0, dclk};
            default:           return {16'h0, pfp, tfp};
        endcase
    endfunction

    initial begin
        repeat (100000) @(posedge clk);
        fail_count++;
        summarize();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        {rst, wr, rd, rst_req, addr, wdata, ref_on, align_req} = '0;
        rst      = 1'b1;
        ce       = 1'b1;
        mode_lvl = 1'b1;
        diff_lvl = 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (30) @(posedge clk);
        for (int k = 0; k < 4; k++) begin
            rd_chk(ofs[k], dflt[k]);
            chk(cfg_out(ofs[k]), dflt[k]);
        end
        chk(diff_drv, 1'b1);
        rd_chk(spc_pkg::OFS_CTRL, 32'h4);
        rd_chk(spc_pkg::OFS_REFSEL, 32'h4);
        for (int k = 0; k < 4; k++) begin
            wr_reg(ofs[k], good[k]);
            chk(cfg_out(ofs[k]), good[k]);
            wr_reg(ofs[k], bad[k]);
            rd_chk(ofs[k], good[k]);
        end
        wr_reg(spc_pkg::OFS_PCLK, 32'h0);
        chk(pclk, 32'h0);
        rd_chk(8'h40, 32'h0);
        // Pin reset with the mode strap low, and a write refused inside it
        mode_lvl <= 1'b0;
        rst_req  <= 1'b1;
        @(posedge clk);
        rst_req <= 1'b0;
        repeat (6) @(posedge clk);
        wr_reg(spc_pkg::OFS_TCLK, 32'h1);
        rd_chk(spc_pkg::OFS_TCLK, 32'h5);
        rd_chk(spc_pkg::OFS_STATUS, 32'h81);
        repeat (spc_pkg::RST_MIN_CYC + 10) @(posedge clk);
        for (int k = 0; k < 4; k++)
            chk(cfg_out(ofs[k]), dflt[k]);
        rd_chk(spc_pkg::OFS_CTRL, 32'h5);
        chk(mode_fr, 1'b1);
        // Clock enable low freezes every register
        @(posedge clk);
        ce <= 1'b0;
        wr_reg(spc_pkg::OFS_PCLK, 32'h200);
        chk({18'h0, pclk}, {18'h0, spc_pkg::PCLK_2M048});
        @(posedge clk);
        ce <= 1'b1;
        // Mode and driver enable from pins and from the control register
        mode_lvl <= 1'b1;
        for (int i = 0; i < 10 && mode_fr !== 1'b0; i++) @(posedge clk);
        chk(mode_fr, 1'b0);
        wr_reg(spc_pkg::OFS_CTRL, 32'h3);
        chk(mode_fr, 1'b1);
        diff_lvl <= 1'b0;
        for (int i = 0; i < 10 && diff_drv !== 1'b0; i++) @(posedge clk);
        chk(diff_drv, 1'b0);
        wr_reg(spc_pkg::OFS_CTRL, 32'hc);
        chk({mode_fr, diff_drv}, 2'b01);
        // Reference selection and paired align inputs
        ref_on <= 3'b010;
        for (int i = 0; i < 3 * WIN && ref_sel !== 2'h1; i++) @(posedge clk);
        chk(ref_sel, 2'h1);
        wr_reg(spc_pkg::OFS_REFSEL, 32'h2);
        chk(ref_sel, 2'h2);
        wr_reg(spc_pkg::OFS_REFSEL, 32'h3);
        chk(ref_sel, 2'h2);
        align(3'b100, 32'h1);
        align(3'b001, 32'h0);
        summarize();
    end
endmodule
